// ===== common/interval_timer_pkg.sv
package interval_timer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_MODE = 8'hEA;
  localparam logic [7:0] OFF_CNT_LO = 8'hEB;
  localparam logic [7:0] OFF_CNT_HI = 8'hEC;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'hF1;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'hF2;
  localparam logic [7:0] OFF_CTRL = 8'hF3;
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_RATE_HI = 6;
  localparam int MODE_RATE_LO = 4;
  localparam int MODE_CKS_BIT = 3;
  localparam logic [7:0] MODE_IMPL_MASK = 8'hF8;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hFFFF;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CAP_BIT = 1;
  localparam int CTRL_IEN_BIT = 0;
  localparam int CTRL_GREEN_BIT = 1;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic enable;
    logic [2:0] rate;
    logic cks;
  } mode_t;

  typedef struct packed {
    logic ovf;
    logic cap;
  } irq_bits_t;

  function automatic logic [31:0] widen8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction
endpackage

// ===== sim/interval_timer_asserts.sv
`timescale 1ns/1ns
module interval_timer_asserts
  import interval_timer_pkg::*;
(
  input logic clk_sys,
  input logic rst_n,
  input logic [ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [DATA_W-1:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [DATA_W-1:0] avs_readdata,
  input logic avs_waitrequest,
  input logic cpu_cycle_tick,
  input logic hosc_tick,
  input logic capture_stop,
  input logic irq,
  input logic wake_request,
  input logic [15:0] count_value
);
  logic wr_ok;
  logic en_q;
  logic [7:0] hi_q;
  logic [2:0] since_ld;
  logic [2:0] off_cnt;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shadow of the enable bit and staged high byte, taken from accepted writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'h0;
      hi_q <= 8'h00;
      since_ld <= 3'h7;
      off_cnt <= 3'h7;
    end else begin
      if (wr_ok && avs_address == OFF_MODE) en_q <= avs_writedata[MODE_EN_BIT];
      if (wr_ok && avs_address == OFF_CNT_HI) hi_q <= avs_writedata[7:0];
      if (wr_ok && avs_address == OFF_CNT_LO) since_ld <= 3'h0;
      else if (since_ld != 3'h7) since_ld <= since_ld + 3'h1;
      // margin for ticks still in the sync pipe after disabling
      if (en_q) off_cnt <= 3'h0;
      else if (off_cnt != 3'h7) off_cnt <= off_cnt + 3'h1;
    end
  end
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence lo_load;
    wr_ok && avs_address == OFF_CNT_LO ##1 1'h1;
  endsequence
  AST_ANSWER:
    assert property (req_wait |=> !avs_waitrequest) else $error("bus answer late");
  AST_ONE_LOW:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  AST_UPPER_ZERO:
    assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_MODE_LOW:
    assert property (avs_read && !avs_waitrequest && avs_address == OFF_MODE |-> avs_readdata[2:0] == 3'h0)
      else $error("mode low bits set");
  AST_WAKE:
    assert property (wake_request |-> irq) else $error("wake without irq");
  AST_STEP:
    assert property ($changed(count_value) && since_ld == 3'h7 |-> count_value == $past(count_value) + 16'h1)
      else $error("count step wrong");
  AST_HOLD:
    assert property (!en_q && off_cnt == 3'h7 && since_ld == 3'h7 |-> $stable(count_value))
      else $error("count moved while disabled");
  AST_LOAD:
    assert property (lo_load |=> count_value == {hi_q, $past(avs_writedata[7:0], 2)}) else $error("load wrong");
  AST_IRQ_FALL:
    assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2)) else $error("irq fell alone");
endmodule
bind interval_timer interval_timer_asserts chk (.*);

// ===== sim/tb_interval_timer.sv
`timescale 1ns/1ns
module tb_interval_timer import interval_timer_pkg::*;;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cpu_cycle_tick = 1'h0;
  logic hosc_tick = 1'h0;
  logic capture_stop = 1'h0;
  logic irq;
  logic wake_request;
  logic [15:0] count_value;
  logic [31:0] q;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  interval_timer uut (.*);
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'h0) break;
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (k == 20) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 8'h00);
    chk(nm, e, q);
  endtask
  // one-cycle source pulses two cycles apart, then let the sync pipe drain
  task automatic pulse(input logic h, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      cpu_cycle_tick <= !h;
      hosc_tick <= h;
      @(posedge clk_sys);
      cpu_cycle_tick <= 1'h0;
      hosc_tick <= 1'h0;
    end
    repeat (6) @(posedge clk_sys);
  endtask
  initial begin
    logic [7:0] m;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(OFF_MODE, 32'h0, "mode");
    rd(OFF_CNT_LO, 32'h0, "cnt_lo");
    rd(OFF_CNT_HI, 32'h0, "cnt_hi");
    rd(8'h00, 32'h0, "unmapped");
    bus(1'h1, OFF_MODE, 8'h7F);
    rd(OFF_MODE, 32'h78, "mode_rw");
    avs_byteenable <= 4'h0;
    bus(1'h1, OFF_MODE, 8'h00);
    avs_byteenable <= 4'hF;
    rd(OFF_MODE, 32'h78, "no_byte_en");
    bus(1'h1, OFF_MODE, 8'h00);
    bus(1'h1, OFF_CNT_HI, 8'h12);
    bus(1'h1, OFF_CNT_LO, 8'hFF);
    pulse(1'h0, 20);
    chk("held", 32'h12FF, {16'h0, count_value});
    bus(1'h1, OFF_MODE, 8'hF0);
    rd(OFF_CNT_LO, 32'hFF, "snap_lo");
    pulse(1'h0, 1);
    rd(OFF_CNT_HI, 32'h12, "snap_hi");
    bus(1'h1, OFF_MODE, 8'h00);
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 8; r++) begin
        m = {1'h0, r[2:0], s[0], 3'h0};
        bus(1'h1, OFF_CNT_HI, 8'h00);
        bus(1'h1, OFF_CNT_LO, 8'h00);
        bus(1'h1, OFF_MODE, m);
        bus(1'h1, OFF_MODE, m | 8'h80);
        pulse(s[0], 256);
        pulse(!s[0], 64);
        bus(1'h1, OFF_MODE, 8'h00);
        chk("rate", 32'h2 << r, {16'h0, count_value});
      end
    end
    bus(1'h1, OFF_CNT_HI, 8'hFF);
    bus(1'h1, OFF_CNT_LO, 8'hFE);
    bus(1'h1, OFF_IRQ_ENABLE, 8'h03);
    bus(1'h1, OFF_CTRL, 8'h01);
    bus(1'h1, OFF_MODE, 8'h70);
    bus(1'h1, OFF_MODE, 8'hF0);
    pulse(1'h0, 2);
    chk("wrap", 32'h0, {16'h0, count_value});
    chk("irq_wake", 32'h3, {30'h0, irq, wake_request});
    rd(OFF_IRQ_STATUS, 32'h1, "status");
    bus(1'h1, OFF_CTRL, 8'h03);
    pulse(1'h0, 1);
    chk("green", 32'h2, {30'h0, irq, wake_request});
    chk("after_wrap", 32'h1, {16'h0, count_value});
    bus(1'h1, OFF_IRQ_ENABLE, 8'h00);
    pulse(1'h0, 0);
    chk("masked", 32'h0, {31'h0, irq});
    rd(OFF_IRQ_STATUS, 32'h1, "sticky");
    bus(1'h1, OFF_IRQ_ENABLE, 8'h03);
    bus(1'h1, OFF_IRQ_CLEAR, 8'h01);
    capture_stop <= 1'h1;
    pulse(1'h0, 0);
    rd(OFF_IRQ_STATUS, 32'h2, "capture");
    chk("cap_irq", 32'h1, {31'h0, irq});
    bus(1'h1, OFF_IRQ_CLEAR, 8'h02);
    pulse(1'h0, 0);
    chk("cleared", 32'h0, {31'h0, irq});
    conclude();
  end
endmodule

// ===== src/interval_timer.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
// Contract
// - enable bit clear holds count, set counts
// - count increments once per prescaled tick
// - wrap from full to zero sets flag
// - no reload, counting continues from zero
// - enabled overflow raises the interrupt output
// - runs in all modes, green never wakes
// - source select: instruction clock or oscillator
// - rate codes divide by 128 down to 1
// - high byte staged, low write loads counter
// - low read snapshots, high read returns half
// - capture stop sets its own flag, shares the interrupt
module interval_timer
  import interval_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_cycle_tick,
  input wire logic hosc_tick,
  input wire logic capture_stop,
  output logic irq,
  output logic wake_request,
  output logic [15:0] count_value
);
  mode_t mode;
  logic [15:0] count;
  logic [7:0] high_stage;
  logic [7:0] high_snap;
  logic [1:0] status;
  logic [1:0] irq_enable;
  logic [1:0] ctrl;
  logic done;
  logic src_tick_sync1;
  logic src_tick_sync2;
  logic cap_sync1;
  logic cap_sync2;
  logic cap_prev;
  logic src_sel;
  logic hosc_sync1;
  logic hosc_sync2;
  logic cpu_sync1;
  logic cpu_sync2;
  logic timer_tick;
  logic bus_req;
  logic wr_ok;
  logic rd_ok;
  logic overflow;
  logic capture_event;
  logic [31:0] next_readdata;
  logic wr_mode;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_clear;
  logic wr_irq_en;
  logic wr_ctrl;
  logic rd_cnt_lo;
  logic pending;

  // one compare per register strobe keeps the decode in one place
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // one-cycle wait: request answered on its second edge
  assign bus_req = (avs_read || avs_write) && !done;
  assign wr_ok = avs_write && done && avs_byteenable[0];
  // reads sample on the first edge, the same edge that loads readdata
  assign rd_ok = avs_read && bus_req;

  // write strobes fire on the edge that the master sees waitrequest low
  assign wr_mode = wr_ok && hit(avs_address, OFF_MODE);
  assign wr_cnt_lo = wr_ok && hit(avs_address, OFF_CNT_LO);
  assign wr_cnt_hi = wr_ok && hit(avs_address, OFF_CNT_HI);
  assign wr_clear = wr_ok && hit(avs_address, OFF_IRQ_CLEAR);
  assign wr_irq_en = wr_ok && hit(avs_address, OFF_IRQ_ENABLE);
  assign wr_ctrl = wr_ok && hit(avs_address, OFF_CTRL);
  assign rd_cnt_lo = rd_ok && hit(avs_address, OFF_CNT_LO);

  // one pending term feeds both irq and wake, so wake never rises without irq
  assign pending = ctrl[CTRL_IEN_BIT] && |(status & irq_enable);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= bus_req;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_req;
    end
  end

  // clock ticks come from other logic; sync them like pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_sync1 <= 1'b0;
      cpu_sync2 <= 1'b0;
      hosc_sync1 <= 1'b0;
      hosc_sync2 <= 1'b0;
      cap_sync1 <= 1'b0;
      cap_sync2 <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      cpu_sync1 <= cpu_cycle_tick;
      cpu_sync2 <= cpu_sync1;
      hosc_sync1 <= hosc_tick;
      hosc_sync2 <= hosc_sync1;
      cap_sync1 <= capture_stop;
      cap_sync2 <= cap_sync1;
      cap_prev <= cap_sync2;
    end
  end

  always_comb begin
    src_sel = mode.cks ? hosc_sync2 : cpu_sync2;
  end

  timer_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(mode.enable),
    .src_tick(src_sel),
    .rate(mode.rate),
    .tick(timer_tick)
  );

  assign overflow = timer_tick && (count == COUNT_FULL);
  assign capture_event = cap_sync2 && !cap_prev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= '0;
    end else if (wr_mode) begin
      // low three bits are not stored
      mode <= mode_t'(avs_writedata[MODE_EN_BIT:MODE_CKS_BIT]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_stage <= COUNT_RESET[15:8];
    end else if (wr_cnt_hi) begin
      high_stage <= avs_writedata[7:0];
    end
  end

  // a software load wins over a tick in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= COUNT_RESET;
    end else if (wr_cnt_lo) begin
      count <= {high_stage, avs_writedata[7:0]};
    end else if (mode.enable && timer_tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_snap <= COUNT_RESET[15:8];
    end else if (rd_cnt_lo) begin
      // same edge as the low byte, so a tick between them cannot tear the pair
      high_snap <= count[15:8];
    end
  end

  // set beats clear in the same cycle; nothing else clears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'b00;
    end else begin
      if (wr_clear) begin
        status[IRQ_OVF_BIT] <= status[IRQ_OVF_BIT] & ~avs_writedata[IRQ_OVF_BIT];
        status[IRQ_CAP_BIT] <= status[IRQ_CAP_BIT] & ~avs_writedata[IRQ_CAP_BIT];
      end
      if (overflow) begin
        status[IRQ_OVF_BIT] <= 1'b1;
      end
      if (capture_event) begin
        status[IRQ_CAP_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= 2'b00;
    end else if (wr_irq_en) begin
      irq_enable <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 2'b00;
    end else if (wr_ctrl) begin
      ctrl <= avs_writedata[1:0];
    end
  end

  // both sources share one vector; the global enable gates them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= pending;
    end
  end

  // green mode keeps counting but raises no wake
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= !ctrl[CTRL_GREEN_BIT] && pending;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= COUNT_RESET;
    end else begin
      count_value <= count;
    end
  end

  always_comb begin
    next_readdata = DATA_ZERO;
    unique case (avs_address)
      OFF_MODE: next_readdata = widen8({mode, 3'b000});
      OFF_CNT_LO: next_readdata = widen8(count[7:0]);
      OFF_CNT_HI: next_readdata = widen8(high_snap);
      OFF_IRQ_STATUS: next_readdata = widen8({6'h00, status});
      OFF_IRQ_ENABLE: next_readdata = widen8({6'h00, irq_enable});
      OFF_CTRL: next_readdata = widen8({6'h00, ctrl});
      default: next_readdata = DATA_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= DATA_ZERO;
    end else if (rd_ok) begin
      avs_readdata <= next_readdata;
    end
  end
endmodule

// ===== src/timer_prescaler.sv
`timescale 1ns/1ns
module timer_prescaler
  import interval_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [2:0] rate,
  output logic tick
);
  logic [6:0] div_count;
  logic [6:0] div_mask;

  // code 000 -> /128, code 111 -> /1
  always_comb begin
    div_mask = 7'h7F >> rate;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= PRESCALE_RESET;
    end else if (!run) begin
      div_count <= PRESCALE_RESET;
    end else if (src_tick) begin
      div_count <= (div_count & div_mask) == div_mask ? PRESCALE_RESET : div_count + 7'h01;
    end
  end

  assign tick = run && src_tick && ((div_count & div_mask) == div_mask);
endmodule
